// File: logic/analog_comparator_control.v
// Control and status logic for one analog comparator behind an APB slave.
//
// How it works
// - Writing comparator_enable 1 turns the comparator on, 0 turns it off.
// - negative_input_select picks external reference pin or internal reference.
// - hysteresis_enable 1 applies about 20mV hysteresis, 0 applies none.
// - Pin driven with the result when pin output and comparator are enabled.
// - The pin carries the raw result, neither registered nor synchronised.
// - The result is synchronised to the clock and readable as synced_compare_result.
// - synced_compare_result reads 0 whenever the comparator is disabled.
// - compare_change_flag sets on a rising or falling synchronised change, except in the first cycle after enabling.
// - An interrupt request stands while compare_change_flag is set.
// - Software clears the flag by writing 0; disabling also clears it.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "comparator_consts.vh"

module analog_comparator_control (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire comparator_raw,
  output reg comparator_on,
  output reg negative_select_internal,
  output reg hysteresis_on,
  output wire comparator_output_pin_out,
  output reg comparator_output_pin_oe,
  output reg compare_irq
);

  // Control fields written by software, followed by internal state and wires.
  reg comparator_enable;
  reg negative_input_select;
  reg hysteresis_enable;
  reg pin_output_enable;
  reg compare_change_flag;
  reg synced_compare_result;
  reg prev_enable;
  reg settled;
  reg [`CMP_SETTLE_WIDTH-1:0] settle_count;
  wire sync_level;
  wire setup_phase;
  wire access_phase;
  wire ctrl_hit;
  wire status_hit;
  wire ctrl_write;
  wire [7:0] wbyte;
  wire change_seen;
  reg [7:0] next_ctrl_read;
  reg [31:0] next_prdata;

  // Reset image of the control register, so single fields can be picked.
  localparam [7:0] CTRL_RESET = `CMP_CTRL_RESET;

  // Packs the control register as software sees it.
  function [7:0] ctrl_image;
    input en;
    input neg;
    input hyst;
    input oe;
    input res;
    input flag;
    reg [7:0] v;
    begin
      v = 8'h00;
      v[`CMP_BIT_ENABLE] = en;
      v[`CMP_BIT_NEG_SEL] = neg;
      v[`CMP_BIT_HYST] = hyst;
      v[`CMP_BIT_PIN_OE] = oe;
      v[`CMP_BIT_RESULT] = res;
      v[`CMP_BIT_FLAG] = flag;
      ctrl_image = v;
    end
  endfunction

  compare_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(comparator_raw),
    .level(sync_level)
  );

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable && pready;
  assign ctrl_hit = (paddr == `CMP_CTRL_ADDR);
  assign status_hit = (paddr == `CMP_STATUS_ADDR);
  // Only byte lane 0 holds the register, so only its strobe writes it.
  assign ctrl_write = access_phase && pwrite && ctrl_hit && pstrb[0];
  assign wbyte = pwdata[7:0];

  // Change detection.
  // A change is only counted while enabled both now and a cycle ago, so
  // switching on does not look like a transition of the result.
  assign change_seen = comparator_enable && prev_enable &&
                       (sync_level != synced_compare_result);

  // Raw pin path.
  // The pin follows the analog result with no clock in the path, as the
  // pin must stay usable when the clock is slow relative to the signal.
  assign comparator_output_pin_out = comparator_raw;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_enable <= CTRL_RESET[`CMP_BIT_ENABLE];
      negative_input_select <= CTRL_RESET[`CMP_BIT_NEG_SEL];
      hysteresis_enable <= CTRL_RESET[`CMP_BIT_HYST];
      pin_output_enable <= CTRL_RESET[`CMP_BIT_PIN_OE];
    end else if (ctrl_write) begin
      comparator_enable <= wbyte[`CMP_BIT_ENABLE];
      negative_input_select <= wbyte[`CMP_BIT_NEG_SEL];
      hysteresis_enable <= wbyte[`CMP_BIT_HYST];
      pin_output_enable <= wbyte[`CMP_BIT_PIN_OE];
    end
  end

  // Analog controls are registered copies of the fields; the pin enable is also gated by comparator_enable.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_on <= 1'b0;
      negative_select_internal <= 1'b0;
      hysteresis_on <= 1'b0;
      comparator_output_pin_oe <= 1'b0;
    end else begin
      comparator_on <= comparator_enable;
      negative_select_internal <= negative_input_select;
      hysteresis_on <= hysteresis_enable;
      comparator_output_pin_oe <= pin_output_enable && comparator_enable;
    end
  end

  // Synchronised result, change flag and interrupt request.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_enable <= 1'b0;
      synced_compare_result <= 1'b0;
      compare_change_flag <= 1'b0;
      compare_irq <= 1'b0;
    end else begin
      prev_enable <= comparator_enable;
      synced_compare_result <= comparator_enable && sync_level;
      if (!comparator_enable) begin
        compare_change_flag <= 1'b0;
      end else if (change_seen) begin
        compare_change_flag <= 1'b1;
      end else if (ctrl_write && !wbyte[`CMP_BIT_FLAG]) begin
        compare_change_flag <= 1'b0;
      end
      compare_irq <= comparator_enable &&
                     (compare_change_flag || change_seen) &&
                     !(ctrl_write && !wbyte[`CMP_BIT_FLAG] && !change_seen);
    end
  end

  // Settling status.
  // The counter restarts on every enable; software may poll the status bit
  // instead of timing the wait itself.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_count <= {`CMP_SETTLE_WIDTH{1'b0}};
      settled <= 1'b0;
    end else if (!comparator_enable) begin
      settle_count <= {`CMP_SETTLE_WIDTH{1'b0}};
      settled <= 1'b0;
    end else if (!settled) begin
      if (settle_count == `CMP_SETTLE_CYCLES - 1) begin
        settled <= 1'b1;
      end
      settle_count <= settle_count + 1'b1;
    end
  end

  // Read data mux, sampled in the setup cycle.
  // Masked when off.
  // The stored result and flag clear one edge after disable; masking here
  // keeps a read right after the disabling write from showing stale bits.
  always @* begin
    next_ctrl_read = ctrl_image(comparator_enable, negative_input_select,
                                hysteresis_enable, pin_output_enable,
                                comparator_enable && synced_compare_result,
                                comparator_enable && compare_change_flag);
    next_prdata = 32'h0000_0000;
    if (ctrl_hit) begin
      next_prdata = {24'h00_0000, next_ctrl_read};
    end else if (status_hit) begin
      next_prdata[`CMP_STAT_SETTLED] = settled;
    end
  end

  // APB answer: ready in the first access cycle, one wait-free transfer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        pslverr <= !(ctrl_hit || (status_hit && !pwrite));
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule // analog_comparator_control

`default_nettype wire

// File: shared/comparator_consts.vh
// Constants for the comparator control block.
`ifndef COMPARATOR_CONSTS_VH
`define COMPARATOR_CONSTS_VH

// Register byte addresses on the APB bus.
`define CMP_CTRL_ADDR 12'h0ac
`define CMP_STATUS_ADDR 12'h0b0
`define CMP_ADDR_WIDTH 12

// Field positions in the control register.
`define CMP_BIT_FLAG 0
`define CMP_BIT_RESULT 1
`define CMP_BIT_PIN_OE 2
`define CMP_BIT_NEG_SEL 3
`define CMP_BIT_RSVD4 4
`define CMP_BIT_ENABLE 5
`define CMP_BIT_HYST 6
`define CMP_BIT_RSVD7 7

// Field positions in the status register.
`define CMP_STAT_SETTLED 0

// Reset values.
`define CMP_CTRL_RESET 8'h00

// Settling time after enable, in nanoseconds, and the clock period.
`define CMP_SETTLE_NS 10000
`define CMP_CLK_PERIOD_NS 5
`define CMP_SETTLE_CYCLES ((`CMP_SETTLE_NS + `CMP_CLK_PERIOD_NS - 1) / `CMP_CLK_PERIOD_NS)
`define CMP_SETTLE_WIDTH 12

`endif

// File: logic/compare_sync.v
// Three-stage synchroniser for the raw comparator result.
`timescale 1ns/1ps
`default_nettype none

module compare_sync (
  input wire pclk,
  input wire presetn,
  input wire async_in,
  output reg level
);

  reg stage1;
  reg stage2;
  reg stage3;

  // A change counts only once the second and third stages agree.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end

endmodule // compare_sync

`default_nettype wire

// File: bench/comparator_core_model.sv
// Behavioural model of the analog comparator core.
`timescale 1ns/1ps
`default_nettype none
module comparator_core_model (
  input wire logic comparator_on,
  input wire logic level,
  output logic raw
);
  // Result only while on.
  // A switched-off core gives a steady low, never the last level.
  assign raw = comparator_on & level;
endmodule // comparator_core_model
`default_nettype wire

// File: bench/analog_comparator_control_properties.sv
// Assertions on the ports of the comparator control block.
`timescale 1ns/1ps
`default_nettype none
`include "comparator_consts.vh"
module comparator_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic comparator_raw,
  input wire logic comparator_on,
  input wire logic negative_select_internal,
  input wire logic hysteresis_on,
  input wire logic comparator_output_pin_out,
  input wire logic comparator_output_pin_oe,
  input wire logic compare_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctl = paddr == `CMP_CTRL_ADDR;
  wire acc = psel && penable && pready;
  pin_raw_a:
    assert property (comparator_output_pin_out == comparator_raw)
    else $error("pin not raw");
  pin_oe_a:
    assert property (comparator_output_pin_oe |-> comparator_on)
    else $error("pin driven while off");
  write_ctrl_a:
    assert property (acc && pwrite && ctl && pstrb[0] |-> ##2
      comparator_on == $past(pwdata[5], 2) &&
      negative_select_internal == $past(pwdata[3], 2) &&
      hysteresis_on == $past(pwdata[6], 2)) else $error("control lost");
  reserved_zero_a:
    assert property (acc && !pwrite && ctl |-> prdata[31:8] == 0 &&
      !prdata[7] && !prdata[4]) else $error("reserved bits set");
  result_off_a:
    assert property (acc && !pwrite && ctl && !comparator_on |->
      prdata[1:0] == 0) else $error("status while off");
  irq_off_a:
    assert property (!comparator_on |-> !compare_irq)
    else $error("irq while off");
  enable_quiet_a:
    assert property ($rose(comparator_on) |-> !compare_irq [*3])
    else $error("enable seen as change");
  unmapped_err_a:
    assert property (psel && !penable && !ctl &&
      paddr != `CMP_STATUS_ADDR |=> pslverr) else $error("no error");
  cover property ($rose(compare_irq));
  cover property (comparator_output_pin_oe);
  cover property (pready && pslverr);
endmodule // comparator_checker
`default_nettype wire

// File: bench/test_analog_comparator_control.sv
// Directed bench for the comparator control block.
`timescale 1ns/1ps
`default_nettype none
`include "comparator_consts.vh"
module test_analog_comparator_control;
  localparam [11:0] ctl = `CMP_CTRL_ADDR;
  logic pclk, presetn, psel, penable, pwrite, level, e;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [7:0] q;
  wire [31:0] prdata;
  wire pready, pslverr, raw, on, nsel, hyst, pin, oe, irq;
  int n_fail, tests_run, cyc;
  analog_comparator_control dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
    .comparator_raw(raw), .comparator_on(on),
    .negative_select_internal(nsel), .hysteresis_on(hyst),
    .comparator_output_pin_out(pin), .comparator_output_pin_oe(oe),
    .compare_irq(irq));
  comparator_core_model core (.comparator_on(on), .level, .raw);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // The whole run needs about 2100 cycles.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test;
    end
  end
  task chk(input string s, input [7:0] x, input [7:0] g);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    // Values read right at the edge are those the slave registered one edge earlier.
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input [7:0] x);
    apb(0, ctl, 8'h00);
    chk("control", x, q);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    level = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(8'h00);
    apb(1, ctl, 8'hfc);
    rd(8'h6c);
    chk("drive", 8'h0f, {4'h0, on, nsel, hyst, oe});
    // Software must let the core settle before trusting it.
    repeat (2000) @(posedge pclk);
    level <= 1;
    repeat (10) @(posedge pclk);
    chk("pin", 8'h01, {7'h00, pin});
    rd(8'h6f);
    chk("irq", 8'h01, {7'h00, irq});
    apb(1, ctl, 8'h6c);
    rd(8'h6e);
    level <= 0;
    repeat (10) @(posedge pclk);
    apb(1, ctl, 8'h6d);
    rd(8'h6d);
    level <= 1;
    apb(1, ctl, 8'h4d);
    rd(8'h4c);
    chk("off", 8'h00, {6'h00, irq, oe});
    apb(0, 12'h0b4, 8'h00);
    chk("error", 8'h01, {7'h00, e});
    chk("unmapped", 8'h00, q);
    end_of_test;
  end
endmodule // test_analog_comparator_control
bind analog_comparator_control comparator_checker chk_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .comparator_raw, .comparator_on, .negative_select_internal,
  .hysteresis_on, .comparator_output_pin_out, .comparator_output_pin_oe,
  .compare_irq);
`default_nettype wire
